// ---- src/tqs_pkg.sv ----
// Purpose: Shared constants for the torque-mode status and speed-limit block.
// Assumes: 10 MHz system clock, AHB-Lite register access, 32-bit data.
// Notes on behaviour
// [RQ1] Motion-active flag stays on for the whole of a motor operation.
// [RQ2] Once on, motion-active holds at least the configured minimum on-time.
// [RQ3] Minimum on-time is set in milliseconds, 0 to 255.
// [RQ4] Motion-active reaches the shared output only when selection one picks it.
// [RQ5] Brake-release reaches the shared output only when selection one picks it.
// [RQ6] Brake-release is on while brake released; controller switches brake from it.
// [RQ7] Zero-speed reaches its output only when selection two picks it.
// [RQ8] Zero-speed is on while measured speed lies inside the zero-speed band.
// [RQ9] Zero-speed band accepts 1 to 5500 r/min.
// [RQ10] Speed-limited turns on when measured speed reaches the active limit.
// [RQ11] Speed-limited turns off once speed drops below the active limit.
// [RQ12] Shaft-free input cuts motor current, leaving no holding torque.
// [RQ13] Shaft-free while brake holds releases the brake; holding is lost.
// [RQ14] Eight records 0 to 7, each a speed limit and a torque command.
// [RQ15] Every record starts with zero speed limit and zero torque command.
// [RQ16] Three selects form the record number, select two most significant.
// [RQ17] Analog enabled: record 0 from knob, record 1 from analog input.
// [RQ18] System-level settings such as analog enable act after next power-up; reset also restores the staged bit, so its default always goes live.
// [RQ19] Internal knob sets speed limit 0 to 5500 r/min, factory value 0.
// [RQ20] Analog gain 0 to 5500 r/min per volt, default 550.
// [RQ21] Auto offset enabled plus apply command captures present input as offset.
// [RQ22] Auto offset disabled subtracts the stored offset voltage from the input.
// [RQ23] Stored offset voltage ranges from -1.00 to 1.00 volts.
package tqs_pkg;

   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned MS_PER_S        = 1000;
   localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_S;

   localparam logic [15:0] SPEED_MAX       = 16'h157C;   // 5500 r/min
   localparam logic [15:0] ZBAND_MIN       = 16'h0001;
   localparam logic [7:0]  MINON_MAX       = 8'hFF;
   localparam logic [15:0] TORQUE_MAX      = 16'h012C;   // 300 percent
   // Analog voltage is signed millivolts; the offset is limited to +/-1000 mV.
   localparam logic signed [15:0] OFS_MAX  = 16'sh03E8;
   localparam logic signed [15:0] OFS_MIN  = -16'sh03E8;

   localparam logic [7:0]  A_CTRL          = 8'h00;
   localparam logic [7:0]  A_MINON         = 8'h04;
   localparam logic [7:0]  A_ZBAND         = 8'h08;
   localparam logic [7:0]  A_GAIN          = 8'h0C;
   localparam logic [7:0]  A_OFS           = 8'h10;
   localparam logic [7:0]  A_STATUS        = 8'h14;
   localparam logic [7:0]  A_SPEED_LIM     = 8'h18;
   localparam logic [7:0]  A_REC_BASE      = 8'h20;   // 8 words, limit [15:0] torque [31:16]

   // Control register fields.
   localparam int unsigned C_SEL1_LO       = 0;       // 2 bits: 0 warn, 1 motion, 2 brake
   localparam int unsigned C_SEL2          = 2;       // 0 zone, 1 zero-speed
   localparam int unsigned C_ANA_EN        = 3;       // system setting, staged
   localparam int unsigned C_AUTO_OFS      = 4;
   localparam int unsigned C_OFS_APPLY     = 5;       // write-one pulse

   localparam logic [1:0]  SEL1_RST        = 2'h1;
   localparam logic [7:0]  MINON_RST       = 8'h00;
   localparam logic [15:0] ZBAND_RST       = 16'h000A;
   localparam logic [15:0] GAIN_RST        = 16'h0226;   // 550 r/min per volt
   localparam logic        ANA_EN_RST      = 1'b1;

   typedef enum logic [2:0]
   {
      MV_IDLE = 3'b001,
      MV_RUN  = 3'b010,
      MV_HOLD = 3'b100
   } tqs_mv_t;

endpackage

// ---- src/tqs_core.sv ----
// Purpose: Status flags, shaft-free control and speed-limit record selection.
// Assumes: Pins and analog samples arrive asynchronously and are resynchronised.
// Notes: Registers reached over AHB-Lite; writes answer at once, reads after one wait state.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
module tqs_core
   import tqs_pkg::*;
#(
   parameter int unsigned CYC_MS = CYC_PER_MS
)
(
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic [31:0]             hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire logic               motor_busy,
   input  wire logic               brake_open_req,
   input  wire logic               warn_in,
   input  wire logic               zone_in,
   input  wire logic               shaft_free,
   input  wire logic [15:0]        speed_abs,
   input  wire logic               record_select_bit0,
   input  wire logic               record_select_bit1,
   input  wire logic               record_select_bit2,
   input  wire logic [15:0]        internal_speed_knob,
   input  wire logic signed [15:0] analog_io_connector,
   output logic                    out_slot1,
   output logic                    out_slot2,
   output logic                    brake_release_flag,
   output logic                    zero_speed_flag,
   output logic                    speed_limited_flag,
   output logic                    current_enable,
   output logic [15:0]             speed_limit_act,
   output logic [15:0]             torque_cmd_act
);

   // Two-flop synchronisers for pins.
   localparam int unsigned NP = 8;
   logic [NP-1:0] pin_raw;
   logic [NP-1:0] pin_s1_r;
   logic [NP-1:0] pin_s2_r;
   assign pin_raw = {record_select_bit2, record_select_bit1, record_select_bit0,
                     shaft_free, zone_in, warn_in, brake_open_req, motor_busy};

   // Each pin is a level, so a two-flop chain per bit is enough; a select change
   // may show a mixed record number for one cycle while the bits settle.
   // Multi-bit samples are assumed slow and held stable by the converters.
   logic [15:0]        spd_s1_r,  spd_s2_r;
   logic [15:0]        knob_s1_r, knob_s2_r;
   logic signed [15:0] ana_s1_r,  ana_s2_r;

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_s1_r  <= '0;
         pin_s2_r  <= '0;
         spd_s1_r  <= '0;
         spd_s2_r  <= '0;
         knob_s1_r <= '0;
         knob_s2_r <= '0;
         ana_s1_r  <= '0;
         ana_s2_r  <= '0;
      end
      else
      begin
         pin_s1_r  <= pin_raw;
         pin_s2_r  <= pin_s1_r;
         spd_s1_r  <= speed_abs;
         spd_s2_r  <= spd_s1_r;
         knob_s1_r <= internal_speed_knob;
         knob_s2_r <= knob_s1_r;
         ana_s1_r  <= analog_io_connector;
         ana_s2_r  <= ana_s1_r;
      end
   end

   wire       busy_s  = pin_s2_r[0];
   wire       brk_s   = pin_s2_r[1];
   wire       warn_s  = pin_s2_r[2];
   wire       zone_s  = pin_s2_r[3];
   wire       free_s  = pin_s2_r[4];
   wire [2:0] rec_sel = pin_s2_r[7:5];   // see [RQ16]

   // AHB-Lite slave.
   logic        ph_wr_r;
   logic        ph_rd_r;
   logic [7:0]  ph_addr_r;
   wire         acc      = hsel && hready && htrans[1];
   wire         wr_now   = ph_wr_r;

   logic [1:0]  sel1_r;
   logic        sel2_r;
   logic        ana_stage_r;
   logic        ana_live_r;
   logic        auto_ofs_r;
   logic [7:0]  minon_r;
   logic [15:0] zband_r;
   logic [15:0] gain_r;
   logic signed [15:0] ofs_r;
   logic signed [15:0] auto_cap_r;
   logic [15:0] rec_lim_r [8];
   logic [15:0] rec_trq_r [8];

   wire [7:0]  wa     = ph_addr_r;
   wire        w_ctrl = wr_now && (wa == A_CTRL);
   wire        w_rec  = wr_now && (wa[7:5] == A_REC_BASE[7:5]);
   wire [2:0]  w_idx  = wa[4:2];

   // Writes above the legal range saturate to the nearest limit; the minimum on-time write keeps only hwdata[7:0].
   wire [15:0] wd_lo  = hwdata[15:0];
   wire [15:0] wd_hi  = hwdata[31:16];
   wire [15:0] zb_in  = (wd_lo < ZBAND_MIN) ? ZBAND_MIN :
                        (wd_lo > SPEED_MAX) ? SPEED_MAX : wd_lo;   // see [RQ9]
   wire [15:0] gn_in  = (wd_lo > SPEED_MAX) ? SPEED_MAX : wd_lo;   // see [RQ20]
   wire signed [15:0] of_raw = $signed(wd_lo);
   wire signed [15:0] of_in  = (of_raw > OFS_MAX) ? OFS_MAX :
                               (of_raw < OFS_MIN) ? OFS_MIN : of_raw;   // see [RQ23]
   wire [15:0] lim_in = (wd_lo > SPEED_MAX) ? SPEED_MAX : wd_lo;
   wire [15:0] trq_in = (wd_hi > TORQUE_MAX) ? TORQUE_MAX : wd_hi;
   // The apply strobe acts only when auto offset was already on before this write.
   wire        ofs_apply = w_ctrl && hwdata[C_OFS_APPLY];

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ph_wr_r   <= 1'b0;
         ph_rd_r   <= 1'b0;
         ph_addr_r <= '0;
      end
      else
      begin
         ph_wr_r   <= acc && hwrite;
         ph_rd_r   <= acc && !hwrite;
         ph_addr_r <= acc ? haddr[7:0] : ph_addr_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sel1_r      <= SEL1_RST;
         sel2_r      <= 1'b1;
         ana_stage_r <= ANA_EN_RST;
         auto_ofs_r  <= 1'b0;
         minon_r     <= MINON_RST;
         zband_r     <= ZBAND_RST;
         gain_r      <= GAIN_RST;   // see [RQ20]
         ofs_r       <= '0;
      end
      else
      begin
         if (w_ctrl)
         begin
            sel1_r      <= hwdata[C_SEL1_LO +: 2];
            sel2_r      <= hwdata[C_SEL2];
            ana_stage_r <= hwdata[C_ANA_EN];
            auto_ofs_r  <= hwdata[C_AUTO_OFS];
         end
         if (wr_now && wa == A_MINON)
            minon_r <= hwdata[7:0];   // see [RQ3]
         if (wr_now && wa == A_ZBAND)
            zband_r <= zb_in;
         if (wr_now && wa == A_GAIN)
            gain_r <= gn_in;
         if (wr_now && wa == A_OFS)
            ofs_r <= of_in;
      end
   end

   // The staged analog enable is copied only at reset release, which stands in
   // for the next power-up; a live change would swap record sources mid-motion.
   logic boot_done_r;
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         boot_done_r <= 1'b0;
         ana_live_r  <= ANA_EN_RST;
      end
      else if (!boot_done_r)
      begin
         boot_done_r <= 1'b1;
         ana_live_r  <= ana_stage_r;   // see [RQ18]
      end
   end

   // Reset also restores the staged value to its default, so a staged change is
   // always lost on any reset; the live copy never moves.

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_rec
         always_ff @(posedge clk_sys or negedge rst_b)
         begin
            if (!rst_b)
            begin
               rec_lim_r[gi] <= '0;   // see [RQ15]
               rec_trq_r[gi] <= '0;   // see [RQ15]
            end
            else if (w_rec && w_idx == 3'(gi))
            begin
               rec_lim_r[gi] <= lim_in;   // see [RQ14]
               rec_trq_r[gi] <= trq_in;
            end
         end
      end
   endgenerate

   // Analog speed limit path.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         auto_cap_r <= '0;
      else if (ofs_apply && auto_ofs_r)
         auto_cap_r <= ana_s2_r;   // see [RQ21]
   end

   wire signed [15:0] ofs_use = auto_ofs_r ? auto_cap_r : ofs_r;   // see [RQ22]
   wire signed [16:0] v_net   = 17'(ana_s2_r) - 17'(ofs_use);
   // A negative net voltage gives a zero limit rather than wrapping to a large one.
   wire [15:0]        v_pos   = v_net[16] ? 16'h0000 : v_net[15:0];
   wire [31:0]        ana_prod = 32'(v_pos) * 32'(gain_r);
   wire [31:0]        ana_rpm  = ana_prod / 32'(MS_PER_S);
   wire [15:0]        ana_lim  = (ana_rpm > 32'(SPEED_MAX)) ? SPEED_MAX : ana_rpm[15:0];
   wire [15:0]        knob_lim = (knob_s2_r > SPEED_MAX) ? SPEED_MAX : knob_s2_r;   // see [RQ19]

   logic [15:0] lim_sel;
   always_comb
   begin
      lim_sel = rec_lim_r[rec_sel];
      if (ana_live_r && rec_sel == 3'd0)
         lim_sel = knob_lim;   // see [RQ17]
      else if (ana_live_r && rec_sel == 3'd1)
         lim_sel = ana_lim;    // see [RQ17]
   end

   // Motion-active state machine with minimum on-time.
   tqs_mv_t     mv_r;
   tqs_mv_t     mv_nxt;
   logic [7:0]  ms_r;
   logic [15:0] sub_r;
   wire         ms_tick = (sub_r == 16'(CYC_MS - 1));
   wire         min_met = (ms_r >= minon_r);

   always_comb
   begin
      case (mv_r)
         MV_IDLE: mv_nxt = busy_s ? MV_RUN : MV_IDLE;
         MV_RUN:  mv_nxt = busy_s ? MV_RUN : (min_met ? MV_IDLE : MV_HOLD);   // see [RQ1]
         MV_HOLD: mv_nxt = busy_s ? MV_RUN : (min_met ? MV_IDLE : MV_HOLD);   // see [RQ2]
         default: mv_nxt = MV_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mv_r  <= MV_IDLE;
         ms_r  <= '0;
         sub_r <= '0;
      end
      else
      begin
         mv_r <= mv_nxt;
         if (mv_r == MV_IDLE)
         begin
            ms_r  <= '0;
            sub_r <= '0;
         end
         else
         begin
            sub_r <= ms_tick ? 16'h0000 : sub_r + 16'h0001;
            // The count saturates at the largest setting so a long move never wraps.
            if (ms_tick && ms_r != MINON_MAX)
               ms_r <= ms_r + 8'h01;
         end
      end
   end

   // The flag follows the next state, so it rises as soon as the busy pin arrives.
   // Shaft-free forces the brake flag on even while the drive would hold the load.
   // With an active limit of zero the limited flag stays on, as any speed reaches it.
   wire mv_flag  = (mv_nxt != MV_IDLE);
   wire brk_flag = brk_s || free_s;   // see [RQ6] see [RQ13]
   wire zv_flag  = (spd_s2_r <= zband_r);   // see [RQ8]
   wire vl_flag  = (spd_s2_r >= lim_sel);   // see [RQ10] see [RQ11]
   wire slot1    = (sel1_r == 2'd1) ? mv_flag :     // see [RQ4]
                   (sel1_r == 2'd2) ? brk_flag :    // see [RQ5]
                   (sel1_r == 2'd0) ? warn_s : 1'b0;
   wire slot2    = sel2_r ? zv_flag : zone_s;       // see [RQ7]

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_slot1          <= 1'b0;
         out_slot2          <= 1'b0;
         brake_release_flag <= 1'b0;
         zero_speed_flag    <= 1'b0;
         speed_limited_flag <= 1'b0;
         current_enable     <= 1'b0;
         speed_limit_act    <= '0;
         torque_cmd_act     <= '0;
      end
      else
      begin
         out_slot1          <= slot1;
         out_slot2          <= slot2;
         brake_release_flag <= brk_flag;
         zero_speed_flag    <= zv_flag;
         speed_limited_flag <= vl_flag;
         current_enable     <= !free_s;   // see [RQ12]
         speed_limit_act    <= lim_sel;
         torque_cmd_act     <= rec_trq_r[rec_sel];
      end
   end

   // Read data.
   wire [31:0] ctrl_rd = {27'h000_0000, auto_ofs_r, ana_stage_r, sel2_r, sel1_r};
   wire [31:0] stat_rd = {24'h00_0000, rec_sel, ana_live_r, vl_flag, zv_flag,
                          brk_flag, mv_flag};
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (wa[7:5] == A_REC_BASE[7:5])
         rd_mux = {rec_trq_r[w_idx], rec_lim_r[w_idx]};
      else
         case (wa)
            A_CTRL:      rd_mux = ctrl_rd;
            A_MINON:     rd_mux = {24'h00_0000, minon_r};
            A_ZBAND:     rd_mux = {16'h0000, zband_r};
            A_GAIN:      rd_mux = {16'h0000, gain_r};
            A_OFS:       rd_mux = {{16{ofs_use[15]}}, ofs_use};
            A_STATUS:    rd_mux = stat_rd;
            A_SPEED_LIM: rd_mux = {16'h0000, lim_sel};
            default:     rd_mux = 32'h0000_0000;
         endcase
   end

   // Reads take one wait state so that the read data leave a flop; the extra
   // cycle also lets a write that lands just before the read be seen by it.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
      end
      else
      begin
         hrdata    <= ph_rd_r ? rd_mux : 32'h0000_0000;
         hreadyout <= !(acc && !hwrite);
      end
   end

   assign hresp = 1'b0;

endmodule // tqs_core

// ---- sim/tqs_chk_sva.sv ----
// Purpose: Port-level checks for the torque status block.
// Assumes: A pin change reaches the flag outputs three edges later.
// Notes: The register contents are not visible here, so only fixed relations are checked.
`timescale 1ns/1ps
module tqs_chk
   import tqs_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic        shaft_free,
   input wire logic        brake_open_req,
   input wire logic [15:0] speed_abs,
   input wire logic        current_enable,
   input wire logic        brake_release_flag,
   input wire logic        zero_speed_flag,
   input wire logic        speed_limited_flag,
   input wire logic [15:0] speed_limit_act
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire brk_src = brake_open_req | shaft_free;
   // Five steady cycles cover the three-edge path through the synchroniser and output flop.
   sequence s_hi;
      (speed_abs >= speed_limit_act && $stable(speed_abs) && $stable(speed_limit_act)) [*5];
   endsequence
   sequence s_lo;
      (speed_abs < speed_limit_act && $stable(speed_abs) && $stable(speed_limit_act)) [*5];
   endsequence
   property p_cut; shaft_free |-> ##3 !current_enable; endproperty
   property p_brk_on; brake_open_req |-> ##3 brake_release_flag; endproperty
   property p_brk_off; !brk_src |-> ##3 !brake_release_flag; endproperty
   property p_free_brk; shaft_free |-> ##3 brake_release_flag; endproperty
   property p_zero_in; speed_abs == 16'h0000 |-> ##3 zero_speed_flag; endproperty
   property p_zero_out; speed_abs > SPEED_MAX |-> ##3 !zero_speed_flag; endproperty
   property p_lim_on; s_hi |-> speed_limited_flag; endproperty
   property p_lim_off; s_lo |-> !speed_limited_flag; endproperty
   a_cut: assert property (p_cut)
      else $error("current not cut while shaft free");
   a_brk_on: assert property (p_brk_on)
      else $error("brake flag missing while brake released");
   a_brk_off: assert property (p_brk_off)
      else $error("brake flag set while brake holds");
   a_free_brk: assert property (p_free_brk)
      else $error("brake not released by shaft free");
   a_zero_in: assert property (p_zero_in)
      else $error("zero speed flag missing at standstill");
   a_zero_out: assert property (p_zero_out)
      else $error("zero speed flag set above band range");
   a_lim_on: assert property (p_lim_on)
      else $error("speed limited flag missing at limit");
   a_lim_off: assert property (p_lim_off)
      else $error("speed limited flag set below limit");
endmodule // tqs_chk

bind tqs_core tqs_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .shaft_free(shaft_free),
   .brake_open_req(brake_open_req), .speed_abs(speed_abs), .current_enable(current_enable),
   .brake_release_flag(brake_release_flag), .zero_speed_flag(zero_speed_flag),
   .speed_limited_flag(speed_limited_flag), .speed_limit_act(speed_limit_act));

// ---- sim/tqs_plc.sv ----
// Purpose: Model of the external controller that picks records and works the brake.
// Assumes: Its outputs change just after a clock edge.
// Notes: The brake coil follows the flag one edge late, as a scanned controller would.
`timescale 1ns/1ps
module tqs_plc
(
   input  wire logic       clk_sys,
   input  wire logic [2:0] rec_num,
   input  wire logic       brake_release_flag,
   output logic            record_select_bit0 = 1'b0,
   output logic            record_select_bit1 = 1'b0,
   output logic            record_select_bit2 = 1'b0,
   output logic            brake_coil_on = 1'b0
);
   always @(posedge clk_sys)
   begin
      record_select_bit0 <= rec_num[0];
      record_select_bit1 <= rec_num[1];
      record_select_bit2 <= rec_num[2];
      brake_coil_on <= brake_release_flag;
   end
endmodule // tqs_plc

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the torque status block.
// Assumes: Registers answer through hreadyout; pin effects settle within six edges.
// Notes: CYC_MS is cut to 4, so one millisecond lasts four cycles.
`timescale 1ns/1ps
module tb_top
   import tqs_pkg::*;
;
   logic        clk_sys = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        motor_busy = 1'b0, brake_open_req = 1'b0, warn_in = 1'b0;
   logic        zone_in = 1'b0, shaft_free = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  rec = 3'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, v, hrdata;
   logic [15:0] speed_abs = 16'h0000, knob = 16'h0000, lim_act, trq_act;
   logic signed [15:0] ana = 16'sh0000;
   logic        hreadyout, hresp, s1, s2, brk, zero, lim, cur, coil, m0, m1, m2;
   int          fail_count = 0, checks = 0, cyc = 0;

   initial forever #50 clk_sys = ~clk_sys;

   tqs_core #(.CYC_MS(4)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .motor_busy(motor_busy), .brake_open_req(brake_open_req), .warn_in(warn_in),
      .zone_in(zone_in), .shaft_free(shaft_free), .speed_abs(speed_abs),
      .record_select_bit0(m0), .record_select_bit1(m1), .record_select_bit2(m2),
      .internal_speed_knob(knob), .analog_io_connector(ana), .out_slot1(s1),
      .out_slot2(s2), .brake_release_flag(brk), .zero_speed_flag(zero),
      .speed_limited_flag(lim), .current_enable(cur), .speed_limit_act(lim_act),
      .torque_cmd_act(trq_act));
   tqs_plc plc (.clk_sys(clk_sys), .rec_num(rec), .brake_release_flag(brk),
      .record_select_bit0(m0), .record_select_bit1(m1), .record_select_bit2(m2),
      .brake_coil_on(coil));

   task automatic close_out;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Sampling at the falling edge reads what the rising edge will take, free of races.
   task automatic ph;
      logic ok;
      do
      begin
         @(negedge clk_sys);
         v = hrdata;
         ok = hreadyout;
         @(posedge clk_sys);
      end while (ok !== 1'b1);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      ph;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      ph;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(n, v, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic t_regs;
      rc("ctrl", A_CTRL, 32'h0000_000D);
      rc("minon", A_MINON, 32'h0000_0000);
      rc("band", A_ZBAND, 32'h0000_000A);
      rc("gain", A_GAIN, 32'h0000_0226);
      rc("unmapped", 8'h40, 32'h0000_0000);
      for (int r = 0; r < 8; r++)
         rc("record", A_REC_BASE + 8'(4 * r), 32'h0000_0000);
   endtask
   task automatic t_recs;
      for (int r = 2; r < 8; r++)
         wr(A_REC_BASE + 8'(4 * r), {16'(r << 4), 16'(r << 8)});
      for (int r = 2; r < 8; r++)
      begin
         @(posedge clk_sys);
         rec <= 3'(r);
         wt(6);
         chk("limit", 32'(lim_act), 32'(r << 8));
         chk("torque", 32'(trq_act), 32'(r << 4));
      end
      @(posedge clk_sys);
      knob <= 16'h04D2;
      ana <= 16'sh07D0;
      rec <= 3'h0;
      wt(6);
      chk("knob", 32'(lim_act), 32'h0000_04D2);
      @(posedge clk_sys);
      rec <= 3'h1;
      wt(6);
      chk("analog", 32'(lim_act), 32'h0000_044C);
   endtask
   task automatic t_ofs;
      wr(A_OFS, 32'h0000_01F4);
      wt(6);
      chk("ofs manual", 32'(lim_act), 32'h0000_0339);
      wr(A_OFS, 32'h0000_07D0);
      rc("ofs clamp", A_OFS, 32'h0000_03E8);
      @(posedge clk_sys);
      ana <= 16'sh0025;
      wt(6);
      wr(A_CTRL, 32'h0000_001D);
      wr(A_CTRL, 32'h0000_003D);
      rc("ofs auto", A_OFS, 32'h0000_0025);
      @(posedge clk_sys);
      ana <= 16'sh07F5;
      wt(6);
      chk("ofs used", 32'(lim_act), 32'h0000_044C);
      wr(A_CTRL, 32'h0000_0015);
      @(posedge clk_sys);
      rec <= 3'h0;
      wt(6);
      chk("staged", 32'(lim_act), 32'h0000_04D2);
   endtask
   task automatic t_motion;
      wr(A_MINON, 32'h0000_00FF);
      rc("minon max", A_MINON, 32'h0000_00FF);
      wr(A_MINON, 32'h0000_0005);
      @(posedge clk_sys);
      motor_busy <= 1'b1;
      @(posedge clk_sys);
      motor_busy <= 1'b0;
      wt(12);
      chk("move held", 32'(s1), 32'h1);
      wt(20);
      chk("move end", 32'(s1), 32'h0);
      @(posedge clk_sys);
      motor_busy <= 1'b1;
      wt(40);
      chk("move long", 32'(s1), 32'h1);
      @(posedge clk_sys);
      motor_busy <= 1'b0;
      wt(6);
      chk("move off", 32'(s1), 32'h0);
      wr(A_CTRL, 32'h0000_0014);
      motor_busy <= 1'b1;
      wt(6);
      chk("slot1 warn", 32'(s1), 32'h0);
      wr(A_CTRL, 32'h0000_0016);
      motor_busy <= 1'b0;
      brake_open_req <= 1'b1;
      wt(6);
      chk("slot1 brake", 32'(s1), 32'h1);
      chk("coil", 32'(coil), 32'h1);
      @(posedge clk_sys);
      brake_open_req <= 1'b0;
      wt(6);
      chk("slot1 hold", 32'(s1), 32'h0);
   endtask
   task automatic t_flags;
      wr(A_CTRL, 32'h0000_0010);
      zone_in <= 1'b1;
      speed_abs <= 16'h000B;
      wt(6);
      chk("slot2 zone", 32'(s2), 32'h1);
      wr(A_CTRL, 32'h0000_0014);
      wt(6);
      chk("slot2 zero", 32'(s2), 32'h0);
      @(posedge clk_sys);
      speed_abs <= 16'h000A;
      wt(6);
      chk("zero edge", 32'(zero), 32'h1);
      wr(A_ZBAND, 32'h0000_0000);
      rc("band min", A_ZBAND, 32'h0000_0001);
      rec <= 3'h3;
      speed_abs <= 16'h02FF;
      wt(6);
      chk("zero out", 32'(zero), 32'h0);
      chk("below", 32'(lim), 32'h0);
      @(posedge clk_sys);
      speed_abs <= 16'h0300;
      wt(6);
      chk("at limit", 32'(lim), 32'h1);
      @(posedge clk_sys);
      speed_abs <= 16'h02FF;
      wt(6);
      chk("dropped", 32'(lim), 32'h0);
      @(posedge clk_sys);
      speed_abs <= 16'h1770;
      wt(6);
      chk("zero high", 32'(zero), 32'h0);
      chk("over", 32'(lim), 32'h1);
   endtask
   task automatic t_free;
      @(posedge clk_sys);
      shaft_free <= 1'b1;
      wt(6);
      chk("cut", 32'(cur), 32'h0);
      chk("free brake", 32'(brk), 32'h1);
      @(posedge clk_sys);
      shaft_free <= 1'b0;
      wt(6);
      chk("restored", 32'(cur), 32'h1);
      chk("brake holds", 32'(brk), 32'h0);
   endtask

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fail_count++;
         close_out;
      end
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_regs;
      t_recs;
      t_ofs;
      t_motion;
      t_flags;
      t_free;
      close_out;
   end
endmodule // tb_top
